// file: dv/sar_adc_sequencer_bench.sv
// Purpose: self-checking bench for the sequencer register port and conversion flow
// Assumes: one system clock; the property checks live in the design files
// Notes: each read queues its expected byte; a monitor compares it a cycle later
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer_bench;
  import sadc_pkg::*;

  typedef struct {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] val;
  } sadc_rdexp_t;

  ////////////////////////////////////////////////////////////////////////////
  // design connections, all inputs driven from time zero
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic sharedAddrSelect = 1'b0;
  logic sleepActive = 1'b0;
  logic rcClkPin = 1'b0;
  logic compOut = 1'b0;
  logic sampleEnable;
  logic [RES_W-1:0] dacCode;
  logic [3:0] inputSelect;
  logic inputValid;
  logic negRefSelect;
  logic posRefSelect;
  logic calibrateActive;
  logic [15:0] pinDigitalIn = '0;
  logic [15:0] pinDigitalSelect;
  logic [15:0] pinDigitalRead;
  logic conversionDoneFlag;

  int failCount = 0;
  int testsRun = 0;
  int seed = 92039;
  sadc_rdexp_t expQ[$];
  logic rdSeen = 1'b0;
  logic [RES_W-1:0] lastRes = '0;
  logic just = 1'b0;

  // 25 ns system clock; rc pin free-running at an unrelated rate
  always #12.5 clk = ~clk;
  always #65 rcClkPin = ~rcClkPin;

  sadc_sequencer #(.LARGE_PACKAGE(1'b1)) sadc_sequencer_inst (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .sharedAddrSelect(sharedAddrSelect), .sleepActive(sleepActive),
    .rcClkPin(rcClkPin), .compOut(compOut), .sampleEnable(sampleEnable),
    .dacCode(dacCode), .inputSelect(inputSelect), .inputValid(inputValid),
    .negRefSelect(negRefSelect), .posRefSelect(posRefSelect),
    .calibrateActive(calibrateActive), .pinDigitalIn(pinDigitalIn),
    .pinDigitalSelect(pinDigitalSelect), .pinDigitalRead(pinDigitalRead),
    .conversionDoneFlag(conversionDoneFlag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare tasks and verdict
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic check_count(input string what, input int lo, input int hi, input int got);
    testsRun++;
    if (got < lo || got > hi) begin
      failCount++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_count

  task automatic giveVerdict();
    if (failCount == 0 && testsRun > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : giveVerdict

  // read data stands only in the cycle after the strobe, so sample it there
  always @(posedge clk) begin
    sadc_rdexp_t e;
    if (rdSeen) begin
      e = expQ.pop_front();
      check_val($sformatf("read index %0d", e.addr), {8'h00, e.val}, {8'h00, regRdData});
    end
    rdSeen <= regRdEn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus tasks: strobes stay up between calls, idle drops them, so no double drive
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    regRdEn <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    expQ.push_back('{addr: a, val: e});
    regAddr <= a;
    regRdEn <= 1'b1;
    regWrEn <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic idle(input int n);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  // result pair in the current justification
  task automatic rd_result();
    if (just) begin
      rd(OFS_RES_HIGH, {6'h00, lastRes[9:8]});
      rd(OFS_RES_LOW, lastRes[7:0]);
    end else begin
      rd(OFS_RES_HIGH, lastRes[9:2]);
      rd(OFS_RES_LOW, {lastRes[1:0], 6'h00});
    end
  endtask : rd_result

  // steady comparator makes the result independent of the sync lag
  task automatic run_conv(input logic [2:0] clkc, input logic [2:0] acq, input logic cal,
                          input int lo, input int hi);
    int cnt;
    logic b;
    b = 1'($random(seed));
    // calibration leaves the stored pair in its old format, so keep it
    if (!cal) just = 1'($random(seed));
    compOut <= b;
    wr(OFS_SHARED_B, {just, cal, acq, clkc});
    wr(OFS_SHARED_A, 8'h01);
    wr(OFS_SHARED_A, 8'h03);
    idle(1);
    rd(OFS_SHARED_A, 8'h03);
    rd(OFS_STATUS, 8'h02);
    idle(1);
    // switch stays closed only while idle, acquiring or in the rc start delay
    check_val("sample enable", 16'((acq != 3'h0) || (&clkc[1:0])), 16'(sampleEnable));
    check_val("calibrate active", 16'(cal), 16'(calibrateActive));
    cnt = 4;
    while (conversionDoneFlag !== 1'b1 && cnt < 3000) begin
      @(posedge clk);
      cnt++;
    end
    check_count("conversion cycles", lo, hi, cnt);
    check_val("result code", 16'({RES_W{b}}), 16'(dacCode));
    if (!cal) begin
      lastRes = {RES_W{b}};
    end
    rd(OFS_SHARED_A, 8'h01);
    // busy still high: the two-period quiet wait follows completion
    rd(OFS_STATUS, 8'h03);
    rd_result();
    wr(OFS_STATUS, 8'h00);
    idle(140);
  endtask : run_conv

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] hv;
    logic [7:0] lv;
    logic [15:0] pv;
    logic [1:0] rf;
    int ex;
    logic [2:0] clkCodes[6];
    int acqT[8];
    clkCodes = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    acqT = '{0, 2, 4, 6, 8, 12, 16, 20};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    // reset values on both shared views, unmapped indices read zero
    for (int s = 0; s < 2; s++) begin
      sharedAddrSelect <= 1'(s);
      idle(1);
      for (int a = 0; a < 8; a++) begin
        if (a != 2 && a != 3) begin
          rd(3'(a), 8'h00);
        end
      end
    end
    // pin configuration through the shared view, left set for the reset check
    hv = 8'($random(seed));
    lv = 8'($random(seed));
    wr(OFS_SHARED_A, hv);
    wr(OFS_SHARED_B, lv);
    rd(OFS_SHARED_A, hv & PIN_HIGH_MASK);
    rd(OFS_SHARED_B, lv & PIN_LOW_MASK);
    pinDigitalIn <= 16'($random(seed));
    idle(6);
    pv = {hv & PIN_HIGH_MASK, lv & PIN_LOW_MASK};
    check_val("pin select", pv, pinDigitalSelect);
    check_val("pin read", pinDigitalIn & pv, pinDigitalRead);
    sharedAddrSelect <= 1'b0;
    idle(1);
    rd(OFS_SHARED_A, 8'h00);
    // every channel code with random reference bits
    for (int c = 0; c < 16; c++) begin
      rf = 2'($random(seed));
      wr(OFS_SHARED_A, {rf, 4'(c), 2'b00});
      idle(3);
      check_val("input and refs", {9'h000, rf, ~(c inside {5, 6, 8, 9}), 4'(c)},
        {9'h000, negRefSelect, posRefSelect, inputValid, inputSelect});
      rd(OFS_SHARED_A, {rf, 4'(c), 2'b00});
    end
    // start request while disabled is dropped
    wr(OFS_SHARED_A, 8'h02);
    idle(2);
    rd(OFS_SHARED_A, 8'h00);
    rd(OFS_STATUS, 8'h00);
    // every divider, every acquisition length
    for (int i = 0; i < 8; i++) begin
      ex = (2 << (i % 6)) * (acqT[i] + 11);
      run_conv(clkCodes[i % 6], 3'(i), 1'b0, ex, ex + 8);
    end
    // calibration keeps the old result but still flags completion
    run_conv(3'h0, 3'h0, 1'b1, 22, 30);
    // rc source keeps running with sleep asserted, one instruction cycle late
    sleepActive <= 1'b1;
    run_conv(3'h3, 3'h0, 1'b0, 55, 90);
    run_conv(3'h7, 3'h0, 1'b0, 55, 90);
    // abort in mid-conversion: opposite comparator, result must not move;
    // sleep still set, so the divided clock must not tick meanwhile
    compOut <= ~lastRes[0];
    wr(OFS_SHARED_B, {just, 7'h06});
    wr(OFS_SHARED_A, 8'h03);
    idle(100);
    check_val("stalled code", 16'(SAR_FIRST_TRIAL), 16'(dacCode));
    sleepActive <= 1'b0;
    wr(OFS_SHARED_A, 8'h01);
    idle(200);
    check_val("flag after abort", 16'h0000, {15'h0000, conversionDoneFlag});
    rd(OFS_STATUS, 8'h00);
    rd_result();
    // reset during a conversion; results survive, pins return to analog
    wr(OFS_SHARED_A, 8'h03);
    idle(50);
    srst <= 1'b1;
    idle(2);
    srst <= 1'b0;
    rd(OFS_SHARED_A, 8'h00);
    rd(OFS_SHARED_B, 8'h00);
    rd(OFS_STATUS, 8'h00);
    rd_result();
    sharedAddrSelect <= 1'b1;
    rd(OFS_SHARED_A, 8'h00);
    rd(OFS_SHARED_B, 8'h00);
    idle(3);
    check_val("pin select after reset", 16'h0000, pinDigitalSelect);
    idle(4);
    giveVerdict();
  end

  // hang guard, well beyond the longest expected run
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    giveVerdict();
  end
endmodule : sar_adc_sequencer_bench
`default_nettype wire

// file: rtl/sadc_pkg.sv
// Purpose: shared constants and types for the successive-approximation sequencer
// Assumes: 8-bit register port, 10-bit result, one system clock
// Notes: offsets index the small register port directly
package sadc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  localparam int CNT_W = 5;

  // register offsets; shared pairs are steered by the external select bit
  localparam logic [ADDR_W-1:0] OFS_SHARED_A = 3'h0; // control or pin high
  localparam logic [ADDR_W-1:0] OFS_SHARED_B = 3'h1; // timing or pin low
  localparam logic [ADDR_W-1:0] OFS_RES_HIGH = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_RES_LOW = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h4;

  // conversion_control fields
  localparam int CTL_NEG_REF = 7;
  localparam int CTL_POS_REF = 6;
  localparam int CTL_CHAN_MSB = 5;
  localparam int CTL_CHAN_LSB = 2;
  localparam int CTL_GO = 1;
  localparam int CTL_ENABLE = 0;

  // conversion_timing_config fields
  localparam int TIM_JUSTIFY = 7;
  localparam int TIM_CAL = 6;
  localparam int TIM_ACQ_MSB = 5;
  localparam int TIM_ACQ_LSB = 3;
  localparam int TIM_CLK_MSB = 2;
  localparam int TIM_CLK_LSB = 0;

  // status fields
  localparam int STAT_FLAG = 0;
  localparam int STAT_BUSY = 1;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PIN_LOW_MASK = 8'h9F;
  localparam logic [DATA_W-1:0] PIN_HIGH_MASK = 8'hFC;

  // timing in conversion-clock periods or system clocks
  localparam logic [CNT_W-1:0] CONV_TADS = 5'h0B;
  localparam logic [CNT_W-1:0] POST_TADS = 5'h02;
  localparam logic [CNT_W-1:0] INSTR_CYCLE_CLKS = 5'h04;
  localparam logic [RES_W-1:0] SAR_FIRST_TRIAL = 10'h200;
  localparam logic [3:0] FIRST_LARGE_CHAN = 4'hC;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RCDLY = 5'h02,
    ST_ACQ = 5'h04,
    ST_CONV = 5'h08,
    ST_WAIT = 5'h10
  } sadc_state_t;

  // acquisition code to periods
  function automatic logic [CNT_W-1:0] acq_tads(input logic [2:0] code);
    logic [CNT_W-1:0] r;
    r = 5'h00;
    unique case (code)
      3'h0: r = 5'h00;
      3'h1: r = 5'h02;
      3'h2: r = 5'h04;
      3'h3: r = 5'h06;
      3'h4: r = 5'h08;
      3'h5: r = 5'h0C;
      3'h6: r = 5'h10;
      3'h7: r = 5'h14;
    endcase
    return r;
  endfunction : acq_tads
endpackage : sadc_pkg

// file: rtl/sadc_sequencer.sv
// Purpose: control and sequencing of a 10-bit successive-approximation converter
// Assumes: comparator, sample switch and input mux are analog, outside this block
// Notes: result registers carry no reset on purpose
`timescale 1ns/10ps
`default_nettype none
module sadc_sequencer
  import sadc_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [sadc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [sadc_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [sadc_pkg::DATA_W-1:0] regRdData,
  // system side
  input wire logic sharedAddrSelect,
  input wire logic sleepActive,
  input wire logic rcClkPin,
  // analog front end
  input wire logic compOut,
  output logic sampleEnable,
  output logic [sadc_pkg::RES_W-1:0] dacCode,
  output logic [3:0] inputSelect,
  output logic inputValid,
  output logic negRefSelect,
  output logic posRefSelect,
  output logic calibrateActive,
  // pins and flag
  input wire logic [15:0] pinDigitalIn,
  output logic [15:0] pinDigitalSelect,
  output logic [15:0] pinDigitalRead,
  output logic conversionDoneFlag
);
  import sadc_pkg::*;

  logic [DATA_W-1:0] ctlReg;
  logic [DATA_W-1:0] timReg;
  logic [DATA_W-1:0] pinLow;
  logic [DATA_W-1:0] pinHigh;
  logic [DATA_W-1:0] resultHigh;
  logic [DATA_W-1:0] resultLow;
  logic goBit;
  sadc_state_t state;
  sadc_state_t next_state;
  logic [CNT_W-1:0] stepCnt;
  logic [RES_W-1:0] trialBit;
  logic tadTick;
  logic compMeta;
  logic compSync;
  logic [15:0] pinMeta;
  logic [15:0] pinSync;
  logic converterOn;
  logic rcMode;
  logic [2:0] acqCode;
  logic [CNT_W-1:0] acqTarget;
  logic doneEvt;
  logic wrCtl;
  logic wrTim;
  logic wrPinLow;
  logic wrPinHigh;
  logic [3:0] chanCode;

  assign converterOn = ctlReg[CTL_ENABLE];
  assign acqCode = timReg[TIM_ACQ_MSB:TIM_ACQ_LSB];
  assign acqTarget = acq_tads(acqCode);
  assign rcMode = timReg[TIM_CLK_LSB+1] & timReg[TIM_CLK_LSB];
  assign chanCode = ctlReg[CTL_CHAN_MSB:CTL_CHAN_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // register decode: select bit low shows control, high shows pin config
  assign wrCtl = regWrEn && (regAddr == OFS_SHARED_A) && !sharedAddrSelect;
  assign wrPinHigh = regWrEn && (regAddr == OFS_SHARED_A) && sharedAddrSelect;
  assign wrTim = regWrEn && (regAddr == OFS_SHARED_B) && !sharedAddrSelect;
  assign wrPinLow = regWrEn && (regAddr == OFS_SHARED_B) && sharedAddrSelect;

  // control and timing bytes; go lives apart since hardware also moves it
  always_ff @(posedge clk) begin
    if (srst) begin
      ctlReg <= REG_RESET;
      timReg <= REG_RESET;
    end else begin
      if (wrCtl) ctlReg <= regWrData & ~(8'h01 << CTL_GO);
      if (wrTim) timReg <= regWrData;
    end
  end

  // start/done: needs converter already on, completion clears it
  always_ff @(posedge clk) begin
    if (srst) begin
      goBit <= 1'b0;
    end else if (!converterOn) begin
      goBit <= 1'b0;
    end else if (doneEvt) begin
      goBit <= 1'b0;
    end else if (wrCtl) begin
      goBit <= regWrData[CTL_GO] & regWrData[CTL_ENABLE];
    end
  end

  // pin configuration; unimplemented bits never store
  always_ff @(posedge clk) begin
    if (srst) begin
      pinLow <= REG_RESET;
      pinHigh <= REG_RESET;
    end else begin
      if (wrPinLow) pinLow <= regWrData & PIN_LOW_MASK;
      if (wrPinHigh) pinHigh <= regWrData & PIN_HIGH_MASK;
    end
  end

  // result pair: no reset so power-up contents stay unknown
  always_ff @(posedge clk) begin
    if (doneEvt && !calibrateActive) begin
      if (timReg[TIM_JUSTIFY]) begin
        resultHigh <= {6'h00, dacCode[9:8]};
        resultLow <= dacCode[7:0];
      end else begin
        resultHigh <= dacCode[9:2];
        resultLow <= {dacCode[1:0], 6'h00};
      end
    end else begin
      if (regWrEn && regAddr == OFS_RES_HIGH) resultHigh <= regWrData;
      if (regWrEn && regAddr == OFS_RES_LOW) resultLow <= regWrData;
    end
  end

  // done flag: set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      conversionDoneFlag <= 1'b0;
    end else if (doneEvt) begin
      conversionDoneFlag <= 1'b1;
    end else if (regWrEn && regAddr == OFS_STATUS && !regWrData[STAT_FLAG]) begin
      conversionDoneFlag <= 1'b0;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst || !regRdEn) begin
      regRdData <= REG_RESET;
    end else begin
      unique case (regAddr)
        OFS_SHARED_A: regRdData <= sharedAddrSelect ? pinHigh
                                   : (ctlReg | (8'(goBit) << CTL_GO));
        OFS_SHARED_B: regRdData <= sharedAddrSelect ? pinLow : timReg;
        OFS_RES_HIGH: regRdData <= resultHigh;
        OFS_RES_LOW: regRdData <= resultLow;
        OFS_STATUS: regRdData <= 8'({state != ST_IDLE, conversionDoneFlag});
        default: regRdData <= REG_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion-clock ticks; sleep halts the divided clock only
  sadc_tad_gen sadc_tad_gen_inst (
    .clk(clk),
    .srst(srst),
    .run(state inside {ST_ACQ, ST_CONV, ST_WAIT}),
    .stall(sleepActive),
    .clkSel(timReg[TIM_CLK_MSB:TIM_CLK_LSB]),
    .rcClkPin(rcClkPin),
    .tadTick(tadTick)
  );

  // completion on the eleventh period of a live conversion
  assign doneEvt = (state == ST_CONV) && tadTick && goBit
                   && (stepCnt == CONV_TADS - 5'h01);

  // sequence: idle, optional rc delay, optional acquisition, conversion, quiet wait
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (goBit) begin
          if (rcMode) next_state = ST_RCDLY;
          else if (acqTarget == 5'h00) next_state = ST_CONV;
          else next_state = ST_ACQ;
        end
      end
      ST_RCDLY: begin
        if (!goBit) next_state = ST_IDLE;
        else if (stepCnt == INSTR_CYCLE_CLKS - 5'h01) begin
          next_state = (acqTarget == 5'h00) ? ST_CONV : ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (!goBit) next_state = ST_WAIT;
        else if (tadTick && stepCnt == acqTarget - 5'h01) next_state = ST_CONV;
      end
      ST_CONV: begin
        if (!goBit || doneEvt) next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (tadTick && stepCnt == POST_TADS - 5'h01) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (!converterOn) next_state = ST_IDLE;
  end

  always_ff @(posedge clk) begin
    if (srst) state <= ST_IDLE;
    else state <= next_state;
  end

  // step counter: system clocks in the rc delay, periods elsewhere
  always_ff @(posedge clk) begin
    if (srst || next_state != state) begin
      stepCnt <= 5'h00;
    end else if (state == ST_RCDLY || tadTick) begin
      stepCnt <= stepCnt + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator synchroniser; second stage is the only reader of the first
  always_ff @(posedge clk) begin
    if (srst) begin
      compMeta <= 1'b0;
      compSync <= 1'b0;
    end else begin
      compMeta <= compOut;
      compSync <= compMeta;
    end
  end

  // successive approximation: ten decisions, then the eleventh period closes
  always_ff @(posedge clk) begin
    if (srst) begin
      dacCode <= 10'h000;
      trialBit <= 10'h000;
      calibrateActive <= 1'b0;
    end else if (state != ST_CONV && next_state == ST_CONV) begin
      dacCode <= SAR_FIRST_TRIAL;
      trialBit <= SAR_FIRST_TRIAL;
      calibrateActive <= timReg[TIM_CAL];
    end else if (state == ST_CONV && tadTick && trialBit != 10'h000) begin
      dacCode <= (compSync ? dacCode : (dacCode & ~trialBit)) | (trialBit >> 1);
      trialBit <= trialBit >> 1;
    end else if (state != ST_CONV) begin
      calibrateActive <= 1'b0;
    end
  end

  // analog controls; sampling pauses during conversion and the wait
  always_ff @(posedge clk) begin
    if (srst) begin
      sampleEnable <= 1'b0;
      inputValid <= 1'b0;
    end else begin
      sampleEnable <= converterOn && (next_state inside {ST_IDLE, ST_RCDLY, ST_ACQ});
      inputValid <= !(chanCode inside {4'h5, 4'h6, 4'h8, 4'h9})
                    && (LARGE_PACKAGE || chanCode < FIRST_LARGE_CHAN);
    end
  end
  assign inputSelect = chanCode;
  assign negRefSelect = ctlReg[CTL_NEG_REF];
  assign posRefSelect = ctlReg[CTL_POS_REF];

  // pin config and digital readback; analog pins read as zero
  assign pinDigitalSelect = {pinHigh[7:2], 2'h0, pinLow[7], 2'h0, pinLow[4:0]};
  always_ff @(posedge clk) begin
    if (srst) begin
      pinMeta <= 16'h0000;
      pinSync <= 16'h0000;
      pinDigitalRead <= 16'h0000;
    end else begin
      pinMeta <= pinDigitalIn;
      pinSync <= pinMeta;
      pinDigitalRead <= pinSync & pinDigitalSelect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper counters read only by the checks
  logic [CNT_W-1:0] chkConvTicks;
  logic [CNT_W-1:0] chkAcqTicks;
  always_ff @(posedge clk) begin
    if (srst || state != ST_CONV) chkConvTicks <= 5'h00;
    else if (tadTick) chkConvTicks <= chkConvTicks + 5'h01;
    if (srst || state != ST_ACQ) chkAcqTicks <= 5'h00;
    else if (tadTick) chkAcqTicks <= chkAcqTicks + 5'h01;
  end

  sequence s_done_then_wait;
    doneEvt ##1 (state == ST_WAIT && conversionDoneFlag && !goBit);
  endsequence

  a_go_needs_on: assert property (@(posedge clk) disable iff (srst)
    !converterOn |=> !goBit) else $error("start/done set while converter off");
  a_done_effects: assert property (@(posedge clk) disable iff (srst)
    doneEvt |-> s_done_then_wait) else $error("completion effects missing");
  a_conv_length: assert property (@(posedge clk) disable iff (srst)
    doneEvt |-> chkConvTicks == 5'd10) else $error("conversion not eleven periods");
  a_acq_length: assert property (@(posedge clk) disable iff (srst)
    (state == ST_ACQ && next_state == ST_CONV) |-> chkAcqTicks + 5'd1 == acqTarget)
    else $error("acquisition length wrong");
  a_abort_keeps: assert property (@(posedge clk) disable iff (srst)
    (state == ST_CONV && !goBit && !regWrEn) |=> $stable(resultHigh) && $stable(resultLow))
    else $error("abort changed result");
  a_rc_delay: assert property (@(posedge clk) disable iff (srst)
    (state == ST_IDLE && next_state == ST_RCDLY && converterOn && !wrCtl)
    |=> (state == ST_RCDLY)[*4]) else $error("rc delay too short");
  a_zero_acq: assert property (@(posedge clk) disable iff (srst)
    (state == ST_IDLE && goBit && converterOn && !rcMode && acqTarget == 5'd0)
    |=> state == ST_CONV) else $error("zero acquisition not immediate");
  a_post_wait: assert property (@(posedge clk) disable iff (srst)
    (state == ST_WAIT && next_state == ST_IDLE && converterOn) |-> stepCnt == 5'd1)
    else $error("post-conversion wait too short");
  a_reset_vals: assert property (@(posedge clk) disable iff (srst)
    $past(srst) |-> ctlReg == 8'h00 && pinLow == 8'h00 && pinHigh == 8'h00 && !goBit)
    else $error("reset values wrong");
  a_analog_zero: assert property (@(posedge clk) disable iff (srst)
    (pinDigitalRead & ~$past(pinDigitalSelect)) == 16'h0000)
    else $error("analog pin reads nonzero");
endmodule : sadc_sequencer
`default_nettype wire

// file: rtl/sadc_tad_gen.sv
// Purpose: conversion-clock tick source, divided system clock or internal rc clock
// Assumes: rc clock pin is asynchronous to clk
// Notes: tick is a one-cycle enable; counter restarts whenever run drops
`timescale 1ns/10ps
`default_nettype none
module sadc_tad_gen (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic run,
  input wire logic stall,
  input wire logic [2:0] clkSel,
  // rc oscillator pin
  input wire logic rcClkPin,
  // tick out
  output logic tadTick
);
  logic rcMeta;
  logic rcSync;
  logic rcPrev;
  logic rcMode;
  logic [2:0] divShift;
  logic [6:0] divCnt;
  logic [6:0] divLast;

  // codes x11 pick the rc source, others give 2..64 system clocks
  assign rcMode = clkSel[1] & clkSel[0];
  assign divShift = 3'({clkSel[1:0], 1'b0}) + 3'(clkSel[2]) + 3'h1;
  assign divLast = 7'((8'h01 << divShift) - 8'h01);

  // rc pin synchroniser; only rcSync feeds the edge detect
  always_ff @(posedge clk) begin
    if (srst) begin
      rcMeta <= 1'b0;
      rcSync <= 1'b0;
      rcPrev <= 1'b0;
    end else begin
      rcMeta <= rcClkPin;
      rcSync <= rcMeta;
      rcPrev <= rcSync;
    end
  end

  // tick generation; stall models the halted system clock in sleep
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      divCnt <= 7'h00;
      tadTick <= 1'b0;
    end else if (rcMode) begin
      tadTick <= rcSync & ~rcPrev;
    end else if (stall) begin
      tadTick <= 1'b0;
    end else if (divCnt == divLast) begin
      divCnt <= 7'h00;
      tadTick <= 1'b1;
    end else begin
      divCnt <= divCnt + 7'h01;
      tadTick <= 1'b0;
    end
  end
endmodule : sadc_tad_gen
`default_nettype wire
